/* verilog/pssr_pkg.sv */
package pssr_pkg;

  // Register offsets on the internal 8-bit register port.
  localparam logic [7:0] PSSR_STATUS_ADDR = 8'h04;
  localparam logic [7:0] PSSR_CAUSE_ADDR = 8'h05;
  localparam logic [7:0] PSSR_RAIL1_ADDR = 8'h20;
  localparam logic [7:0] PSSR_RAIL2_ADDR = 8'h21;

  // Field positions.
  localparam int PSSR_DIE_HOT_BIT = 0;
  localparam int PSSR_CRIT_BIT = 0;
  localparam int PSSR_PFAULT_BIT = 1;
  localparam int PSSR_UV_BIT = 2;
  localparam int PSSR_COLD_BIT = 3;
  localparam int PSSR_CAUSE_W = 3;

  // Reset and read values.
  localparam logic [7:0] PSSR_ZERO_BYTE = 8'h00;
  localparam logic [PSSR_CAUSE_W-1:0] PSSR_CAUSE_RESET = 3'h0;
  localparam logic [3:0] PSSR_SENSE_RESET = 4'h0;

  // Sensed conditions from the analog and sequencing logic.
  typedef struct packed {
    logic uv;
    logic pfault;
    logic crit;
    logic hot;
  } pssr_sense_t;

  // Normal-mode control of one step-down controller.
  typedef struct packed {
    logic [6:0] code;
    logic decay;
  } pssr_rail_t;

endpackage : pssr_pkg

/* verilog/pssr_regs.sv */
`timescale 1ns/1ps
module pssr_regs (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Register port from the serial target logic
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // Asynchronous sensed conditions
  input wire pssr_pkg::pssr_sense_t i_sense,
  // Factory programmed rail defaults
  input wire pssr_pkg::pssr_rail_t i_rail1_otp,
  input wire pssr_pkg::pssr_rail_t i_rail2_otp,
  // Rail controls
  output pssr_pkg::pssr_rail_t o_rail1,
  output pssr_pkg::pssr_rail_t o_rail2,
  // Toward the interrupt register
  output logic o_shutdown_set,
  output logic o_cause_pending
);
  import pssr_pkg::*;

  pssr_sense_t s1_q, s2_q, s3_q, filt_q;
  pssr_sense_t s1_d, s2_d, s3_d, filt_d, rise;
  logic [PSSR_CAUSE_W-1:0] cause_q, cause_d, cause_set, cause_clr;
  logic shut_q, shut_d;
  logic load_done_q, load_done_d;
  pssr_rail_t rail1_q, rail1_d, rail2_q, rail2_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;

  function automatic logic hit(input logic en, input logic [7:0] a,
                               input logic [7:0] ref_a);
    hit = en && (a == ref_a);
  endfunction : hit

  // A change counts only once stages two and three agree.
  always_comb begin
    s1_d = i_sense;
    s2_d = s1_q;
    s3_d = s2_q;
    filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    rise = filt_d & ~filt_q;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q <= PSSR_SENSE_RESET;
      s2_q <= PSSR_SENSE_RESET;
      s3_q <= PSSR_SENSE_RESET;
      filt_q <= PSSR_SENSE_RESET;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      filt_q <= filt_d;
    end
  end

  // A new event in the clearing cycle wins over the clear.
  always_comb begin
    cause_set = PSSR_CAUSE_RESET;
    cause_set[PSSR_UV_BIT] = rise.uv;
    cause_set[PSSR_PFAULT_BIT] = rise.pfault;
    cause_set[PSSR_CRIT_BIT] = rise.crit;
    cause_clr = PSSR_CAUSE_RESET;
    if (hit(i_wr_en, i_addr, PSSR_CAUSE_ADDR)) begin
      cause_clr = i_wr_data[PSSR_CAUSE_W-1:0];
    end
    cause_d = (cause_q & ~cause_clr) | cause_set;
    shut_d = |cause_set;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cause_q <= PSSR_CAUSE_RESET;
      shut_q <= 1'b0;
    end else begin
      cause_q <= cause_d;
      shut_q <= shut_d;
    end
  end

  // Factory values are taken at the first edge after release, since an
  // asynchronous reset may only load constants.
  always_comb begin
    load_done_d = 1'b1;
    rail1_d = rail1_q;
    rail2_d = rail2_q;
    if (!load_done_q) begin
      rail1_d = i_rail1_otp;
      rail2_d = i_rail2_otp;
    end else begin
      if (hit(i_wr_en, i_addr, PSSR_RAIL1_ADDR)) begin
        rail1_d = i_wr_data;
      end
      if (hit(i_wr_en, i_addr, PSSR_RAIL2_ADDR)) begin
        rail2_d = i_wr_data;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      load_done_q <= 1'b0;
      rail1_q <= PSSR_ZERO_BYTE;
      rail2_q <= PSSR_ZERO_BYTE;
    end else begin
      load_done_q <= load_done_d;
      rail1_q <= rail1_d;
      rail2_q <= rail2_d;
    end
  end

  // Unmapped offsets read as zero.
  always_comb begin
    rd_valid_d = i_rd_en;
    rd_data_d = PSSR_ZERO_BYTE;
    if (i_rd_en) begin
      case (i_addr)
        PSSR_STATUS_ADDR: begin
          rd_data_d[PSSR_DIE_HOT_BIT] = filt_q.hot;
        end
        PSSR_CAUSE_ADDR: begin
          rd_data_d[PSSR_CAUSE_W-1:0] = cause_q;
        end
        PSSR_RAIL1_ADDR: begin
          rd_data_d = rail1_q;
        end
        PSSR_RAIL2_ADDR: begin
          rd_data_d = rail2_q;
        end
        default: begin
          rd_data_d = PSSR_ZERO_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_data_q <= PSSR_ZERO_BYTE;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_rail1 = rail1_q;
  assign o_rail2 = rail2_q;
  assign o_shutdown_set = shut_q;
  // The interrupt register holds its shutdown flag while this is high.
  assign o_cause_pending = |cause_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence status_read_s;
    i_rd_en && i_addr == PSSR_STATUS_ADDR;
  endsequence
  sequence cause_read_s;
    i_rd_en && i_addr == PSSR_CAUSE_ADDR;
  endsequence

  hot_status_read_a: assert property (
    status_read_s |=> o_rd_valid &&
      o_rd_data == {7'h00, $past(filt_q.hot)})
    else $error("die hot status read wrong");
  cause_sticky_a: assert property (
    cause_q[PSSR_UV_BIT] && !(i_wr_en && i_addr == PSSR_CAUSE_ADDR)
      |=> cause_q[PSSR_UV_BIT])
    else $error("cause flag dropped without clear");
  uv_cause_set_a: assert property (
    s2_q.uv && s3_q.uv && !filt_q.uv |=> cause_q[PSSR_UV_BIT])
    else $error("undervoltage cause not set");
  shutdown_pulse_a: assert property (
    $rose(filt_q.pfault) || $rose(filt_q.crit) || $rose(filt_q.uv)
      |-> o_shutdown_set ##1 (!o_shutdown_set || $rose(filt_q.pfault) ||
      $rose(filt_q.crit) || $rose(filt_q.uv)))
    else $error("shutdown indication not pulsed");
  pfault_cause_set_a: assert property (
    $rose(filt_q.pfault) |-> cause_q[PSSR_PFAULT_BIT])
    else $error("power fault cause not set");
  crit_cause_set_a: assert property (
    $rose(filt_q.crit) |-> cause_q[PSSR_CRIT_BIT])
    else $error("critical temperature cause not set");
  cause_read_upper_a: assert property (
    cause_read_s |=> o_rd_data[7:PSSR_COLD_BIT] == 5'h00 &&
      o_rd_data[PSSR_CAUSE_W-1:0] == $past(cause_q))
    else $error("cause read shows cold-off or reserved bits");
  rail1_write_a: assert property (
    load_done_q && i_wr_en && i_addr == PSSR_RAIL1_ADDR
      |=> o_rail1 == $past(i_wr_data))
    else $error("rail1 control write lost");
  rail2_decay_a: assert property (
    load_done_q && i_wr_en && i_addr == PSSR_RAIL2_ADDR
      |=> o_rail2.decay == $past(i_wr_data[0]))
    else $error("rail2 decay select write lost");
  otp_load_a: assert property (
    $rose(load_done_q) |-> o_rail1 == $past(i_rail1_otp) &&
      o_rail2 == $past(i_rail2_otp))
    else $error("factory rail values not loaded");
  zero_write_keeps_a: assert property (
    cause_q[PSSR_CRIT_BIT] && i_wr_en && i_addr == PSSR_CAUSE_ADDR &&
      !i_wr_data[PSSR_CRIT_BIT] |=> cause_q[PSSR_CRIT_BIT])
    else $error("zero write cleared a cause flag");

endmodule : pssr_regs

/* test/pssr_host.sv */
`timescale 1ns/1ps
module pssr_host (
  // Clock
  input wire logic i_clk,
  // Read answer
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid,
  // Register requests
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'hff;
    o_wr_data = 8'hff;
  end
  // Idle address and data are inverted so a stale value is never reused.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wr_data = d;
    @(posedge i_clk) #1;
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    o_rd_en = 1'b1;
    o_addr = a;
    @(posedge i_clk) #1;
    o_rd_en = 1'b0;
    o_addr = ~a;
    d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
  endtask : rd
endmodule : pssr_host

/* test/pssr_regs_tb.sv */
`timescale 1ns/1ps
module pssr_regs_tb;
  import pssr_pkg::*;
  localparam logic [7:0] OTP1 = 8'h6b;
  localparam logic [7:0] OTP2 = 8'h54;
  logic clk, nrst, wr_en, rd_en, rvalid, sd_set, pend;
  logic [7:0] addr, wdata, rdata, v;
  pssr_sense_t sense;
  pssr_rail_t rail1, rail2;
  int err_total, n_tests, pulses;
  pssr_regs dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wdata), .o_rd_data(rdata),
    .o_rd_valid(rvalid), .i_sense(sense), .i_rail1_otp(OTP1),
    .i_rail2_otp(OTP2), .o_rail1(rail1), .o_rail2(rail2),
    .o_shutdown_set(sd_set), .o_cause_pending(pend));
  pssr_host host_u (.i_clk(clk), .i_rd_data(rdata), .i_rd_valid(rvalid),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wdata));
  // Counted mid-cycle so the registered pulse is sampled while it stands.
  always @(negedge clk) if (sd_set === 1'b1) pulses++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("%0d compares, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic t_reset;
    chk(rail1, OTP1);
    chk(rail2, OTP2);
    host_u.rd(PSSR_CAUSE_ADDR, v);
    chk(v, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_rails;
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h01 : 8'hfe;
      host_u.wr(PSSR_RAIL1_ADDR, v);
      host_u.wr(PSSR_RAIL2_ADDR, ~v);
      chk(rail1, v);
      chk(rail2, ~v);
      host_u.rd(PSSR_RAIL2_ADDR, v);
      chk(v, i ? 8'hfe : 8'h01);
      host_u.rd(PSSR_RAIL1_ADDR, v);
      chk(v, i ? 8'h01 : 8'hfe);
    end
    $display("test rails done");
  endtask : t_rails
  task automatic t_hot;
    sense.hot = 1'b1;
    repeat (5) @(posedge clk);
    host_u.wr(PSSR_STATUS_ADDR, 8'h00);
    host_u.rd(PSSR_STATUS_ADDR, v);
    chk(v, 8'h01);
    sense.hot = 1'b0;
    repeat (5) @(posedge clk);
    host_u.rd(PSSR_STATUS_ADDR, v);
    chk(v, 8'h00);
    $display("test hot done");
  endtask : t_hot
  task automatic t_cause;
    logic [7:0] m;
    int p;
    for (int b = 0; b < 3; b++) begin
      m = 8'h01 << b;
      p = pulses;
      sense[b+1] = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk(8'(pulses - p), 8'h01);
      chk({7'h00, pend}, 8'h01);
      sense[b+1] = 1'b0;
      host_u.rd(PSSR_CAUSE_ADDR, v);
      chk(v, m);
      host_u.wr(PSSR_CAUSE_ADDR, 8'hf8 | (8'h07 & ~m));
      host_u.rd(PSSR_CAUSE_ADDR, v);
      chk(v, m);
      host_u.wr(PSSR_CAUSE_ADDR, m);
      host_u.rd(PSSR_CAUSE_ADDR, v);
      chk(v, 8'h00);
      chk({7'h00, pend}, 8'h00);
    end
    $display("test cause done");
  endtask : t_cause
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    sense = PSSR_SENSE_RESET;
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk) #1;
    t_reset();
    t_rails();
    t_hot();
    t_cause();
    results();
  end
  initial begin
    #200us;
    err_total++;
    results();
  end
endmodule : pssr_regs_tb
